/* macrocell_pkg.sv */
// shared constants for the output macrocell block
package macrocell_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] cfg_addr    = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [7:0] terms_addr  = 8'h08;

    // ==========================================================
    // configuration field layout
    localparam int type_lsb    = 0;   // 3 bits: flip-flop type / bypass
    localparam int pol_bit     = 3;   // output polarity, 1 = active low
    localparam int csel_bit    = 4;   // 1 = term_clock_select
    localparam int oe_vcc_bit  = 5;   // output enable tied true
    localparam int fb_lsb      = 6;   // 2 bits: feedback choice
    localparam int buried_bit  = 8;   // register does not drive pin
    localparam logic [31:0] cfg_mask  = 32'h0000_01ff;
    localparam logic [31:0] cfg_reset = 32'h0000_0000;

    // status field layout
    localparam int st_q_bit    = 0;
    localparam int st_pin_bit  = 1;
    localparam int st_oe_bit   = 2;
    localparam int st_fb_bit   = 3;
    localparam int st_fbok_bit = 4;

    // product term inputs, written by software in place of array
    localparam int t_a_bit   = 0;     // d / t / j / s input term
    localparam int t_b_bit   = 1;     // k / r input term
    localparam int t_comb_bit = 2;    // combinatorial sum term
    localparam int t_ck_bit  = 3;     // shared clock / enable term
    localparam logic [31:0] terms_mask = 32'h0000_000f;

    // ==========================================================
    // output modes
    typedef enum logic [2:0] {
        mode_comb = 3'h0,
        mode_d    = 3'h1,
        mode_t    = 3'h2,
        mode_jk   = 3'h3,
        mode_sr   = 3'h4
    } out_mode_t;

    // feedback choices
    typedef enum logic [1:0] {
        fb_none = 2'h0,
        fb_pin  = 2'h1,
        fb_nq   = 2'h2
    } fb_sel_t;

    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [2:0] hsize_word    = 3'h2;

endpackage

/* macrocell_core.sv */
// one output macrocell: register, clock choice, enable, feedback
`timescale 1ns/100ps

module macrocell_core (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] mode,
    input  wire logic       polarity_low,
    input  wire logic       term_clock_select,
    input  wire logic       oe_forced,
    input  wire logic [1:0] fb_choice,
    input  wire logic       buried,
    input  wire logic       term_a,
    input  wire logic       term_b,
    input  wire logic       term_comb,
    input  wire logic       term_ck,
    input  wire logic       clock_pin_a,
    output logic            q_r,
    output logic            pin_level,
    output logic            oe_level,
    output logic            feedback,
    output logic            feedback_ok
);

    // ==========================================================
    // clock edge detect (all on hclk, one domain)
    logic pin_d_r;
    logic ck_d_r;
    logic clk_edge;
    logic q_nxt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_d_r <= 1'b0;
            ck_d_r  <= 1'b0;
            q_r     <= 1'b0;
        end else begin
            pin_d_r <= clock_pin_a;
            ck_d_r  <= term_ck;
            q_r     <= q_nxt;
        end
    end

    // ==========================================================
    // next state by flip-flop type on rising edge of chosen clock
    always_comb begin
        clk_edge = term_clock_select ? (term_ck & ~ck_d_r)
                                     : (clock_pin_a & ~pin_d_r);
        q_nxt = q_r;
        if (clk_edge) begin
            case (mode)
                macrocell_pkg::mode_d:  q_nxt = term_a;
                macrocell_pkg::mode_t:  q_nxt = q_r ^ term_a;
                macrocell_pkg::mode_jk: q_nxt = (term_a & ~q_r) | (~term_b & q_r);
                macrocell_pkg::mode_sr: q_nxt = term_a ? 1'b1 : (term_b ? 1'b0 : q_r);
                default:                q_nxt = q_r;
            endcase
        end
    end

    // ==========================================================
    // pin, enable and feedback; term_ck is a single product term
    logic core_val;
    always_comb begin
        core_val  = (mode == macrocell_pkg::mode_comb) ? term_comb : q_r;
        pin_level = core_val ^ polarity_low;
        if (buried && mode != macrocell_pkg::mode_comb) begin
            oe_level = 1'b0;
        end else if (term_clock_select || oe_forced) begin
            oe_level = 1'b1;
        end else begin
            oe_level = term_ck;
        end
        feedback    = 1'b0;
        feedback_ok = 1'b0;
        case (fb_choice)
            macrocell_pkg::fb_pin: begin
                feedback_ok = (mode == macrocell_pkg::mode_comb)
                           || (mode == macrocell_pkg::mode_d)
                           || (mode == macrocell_pkg::mode_t);
                feedback = feedback_ok & pin_level;
            end
            macrocell_pkg::fb_nq: begin
                feedback_ok = (mode != macrocell_pkg::mode_comb)
                           && (mode <= macrocell_pkg::mode_sr);
                feedback = feedback_ok & ~q_r;
            end
            default: begin
                feedback    = 1'b0;
                feedback_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // checks
    AST_PT_CLOCK_OE_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        (term_clock_select && !buried) |-> oe_level)
        else $error("enable not held with term clock");
    AST_PIN_CLOCK_OE_TERM: assert property (@(posedge hclk) disable iff (!hresetn)
        (!term_clock_select && !oe_forced && !buried) |-> (oe_level == term_ck))
        else $error("enable not from shared term");
    AST_D_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == macrocell_pkg::mode_d && clk_edge) |=> (q_r == $past(term_a)))
        else $error("d capture wrong");
    AST_T_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == macrocell_pkg::mode_t && clk_edge && term_a) |=> (q_r != $past(q_r)))
        else $error("t toggle missing");
    AST_NO_EDGE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_edge |=> $stable(q_r))
        else $error("state moved without edge");
    AST_PIN_FB_JK: assert property (@(posedge hclk) disable iff (!hresetn)
        (fb_choice == macrocell_pkg::fb_pin && mode == macrocell_pkg::mode_jk) |-> !feedback_ok)
        else $error("pin feedback allowed for jk");
    AST_NQ_FB_COMB: assert property (@(posedge hclk) disable iff (!hresetn)
        (fb_choice == macrocell_pkg::fb_nq && mode == macrocell_pkg::mode_comb) |-> !feedback_ok)
        else $error("inverted feedback allowed for comb");
    AST_BURIED_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (buried && mode != macrocell_pkg::mode_comb) |-> !oe_level)
        else $error("buried register drives pin");

endmodule // macrocell_core

/* macrocell_top.sv */
// ahb-lite wrapper with configuration and status of the macrocell
`timescale 1ns/100ps

// Contract
// - clock from pin or shared term
// - pin clock: shared term drives enable unless enable forced on or register buried
// - term clock: output enabled unless register buried
// - shared control is one product term
// - term clock plus forced enable ties on unless register buried
// - d, t, jk, sr with selectable polarity
// - five modes incl. combinatorial bypass
// - pin feedback only comb, d, t
// - inverted feedback only registered modes
// - buried register feeds array, pin off
module macrocell_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        clock_pin_a,
    input  wire logic        clock_pin_b,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             out_pin_o,
    output logic             out_pin_oe,
    output logic             array_feedback
);

    // all checks in this module run on the bus clock
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // pin synchronisers: first stage read only by second
    logic [1:0] ca_sync_r;
    logic [1:0] cb_sync_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ca_sync_r <= 2'h0;
            cb_sync_r <= 2'h0;
        end else begin
            ca_sync_r <= {ca_sync_r[0], clock_pin_a};
            cb_sync_r <= {cb_sync_r[0], clock_pin_b};
        end
    end

    // ==========================================================
    // ahb-lite slave: zero wait, okay always
    logic        wr_pend_r;
    logic        wr_pend_nxt;
    logic [7:0]  wr_addr_r;
    logic [7:0]  wr_addr_nxt;
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [31:0] terms_r;
    logic [31:0] terms_nxt;
    logic [31:0] hrdata_nxt;
    logic [31:0] status_w;
    logic        accept;

    function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] c,
                                             input logic [31:0] s, input logic [31:0] t);
        case (a)
            macrocell_pkg::cfg_addr:    read_mux = c;
            macrocell_pkg::status_addr: read_mux = s;
            macrocell_pkg::terms_addr:  read_mux = t;
            default:                    read_mux = 32'h0000_0000;
        endcase
    endfunction

    // address phase capture and data phase write
    always_comb begin
        accept      = hsel && hready && (htrans == macrocell_pkg::htrans_nonseq);
        wr_pend_nxt = accept && hwrite;
        wr_addr_nxt = accept ? haddr[7:0] : wr_addr_r;
        cfg_nxt     = cfg_r;
        terms_nxt   = terms_r;
        if (wr_pend_r && wr_addr_r == macrocell_pkg::cfg_addr) begin
            cfg_nxt = hwdata & macrocell_pkg::cfg_mask;
        end
        if (wr_pend_r && wr_addr_r == macrocell_pkg::terms_addr) begin
            terms_nxt = hwdata & macrocell_pkg::terms_mask;
        end
        hrdata_nxt = (accept && !hwrite) ? read_mux(haddr[7:0], cfg_r, status_w, terms_r)
                                         : hrdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            cfg_r     <= macrocell_pkg::cfg_reset;
            terms_r   <= 32'h0000_0000;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            cfg_r     <= cfg_nxt;
            terms_r   <= terms_nxt;
            hrdata    <= hrdata_nxt;
        end
    end

    // bus always ready; errors never raised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================================
    // macrocell; clock pin b is kept for the second cell pairing
    logic q_w;
    logic pin_w;
    logic oe_w;
    logic fb_w;
    logic fbok_w;

    macrocell_core u_cell (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .mode              (cfg_r[macrocell_pkg::type_lsb +: 3]),
        .polarity_low      (cfg_r[macrocell_pkg::pol_bit]),
        .term_clock_select (cfg_r[macrocell_pkg::csel_bit]),
        .oe_forced         (cfg_r[macrocell_pkg::oe_vcc_bit]),
        .fb_choice         (cfg_r[macrocell_pkg::fb_lsb +: 2]),
        .buried            (cfg_r[macrocell_pkg::buried_bit]),
        .term_a            (terms_r[macrocell_pkg::t_a_bit]),
        .term_b            (terms_r[macrocell_pkg::t_b_bit]),
        .term_comb         (terms_r[macrocell_pkg::t_comb_bit]),
        .term_ck           (terms_r[macrocell_pkg::t_ck_bit]),
        .clock_pin_a       (ca_sync_r[1]),
        .q_r               (q_w),
        .pin_level         (pin_w),
        .oe_level          (oe_w),
        .feedback          (fb_w),
        .feedback_ok       (fbok_w)
    );

    // status word shows cell state; synced pin b drops out of the fb ok bit
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[macrocell_pkg::st_q_bit]    = q_w;
        status_w[macrocell_pkg::st_pin_bit]  = pin_w;
        status_w[macrocell_pkg::st_oe_bit]   = oe_w;
        status_w[macrocell_pkg::st_fb_bit]   = fb_w;
        status_w[macrocell_pkg::st_fbok_bit] = fbok_w & ~cb_sync_r[1] | fbok_w;
    end

    // registered pin outputs, one cycle behind the cell
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_pin_o      <= 1'b0;
            out_pin_oe     <= 1'b0;
            array_feedback <= 1'b0;
        end else begin
            out_pin_o      <= pin_w;
            out_pin_oe     <= oe_w;
            array_feedback <= fb_w;
        end
    end

    AST_OUT_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (out_pin_oe == $past(oe_w)))
        else $error("pin enable not registered from cell");

    // ==========================================================
    // field views of the configuration word, for the checks below
    logic [2:0] cfg_mode_w;
    logic [1:0] cfg_fb_w;
    logic       cfg_pol_w;
    logic       cfg_csel_w;
    logic       cfg_frc_w;
    logic       cfg_bur_w;
    logic       reg_mode_w;
    logic       d_pin_w;
    logic       d_term_w;
    always_comb begin
        cfg_mode_w = cfg_r[macrocell_pkg::type_lsb +: 3];
        cfg_fb_w   = cfg_r[macrocell_pkg::fb_lsb +: 2];
        cfg_pol_w  = cfg_r[macrocell_pkg::pol_bit];
        cfg_csel_w = cfg_r[macrocell_pkg::csel_bit];
        cfg_frc_w  = cfg_r[macrocell_pkg::oe_vcc_bit];
        cfg_bur_w  = cfg_r[macrocell_pkg::buried_bit];
        // codes above the last flip-flop type leave the register idle
        reg_mode_w = (cfg_mode_w != macrocell_pkg::mode_comb)
                  && (cfg_mode_w <= macrocell_pkg::mode_sr);
        d_pin_w    = (cfg_mode_w == macrocell_pkg::mode_d) && !cfg_csel_w;
        d_term_w   = (cfg_mode_w == macrocell_pkg::mode_d) && cfg_csel_w;
    end

    // ==========================================================
    // bus steps: address phase taken at one edge, data at the next
    sequence seq_cfg_write;
        accept && hwrite && (haddr[7:0] == macrocell_pkg::cfg_addr);
    endsequence

    sequence seq_terms_write;
        accept && hwrite && (haddr[7:0] == macrocell_pkg::terms_addr);
    endsequence

    sequence seq_cfg_read;
        accept && !hwrite && (haddr[7:0] == macrocell_pkg::cfg_addr);
    endsequence

    sequence seq_terms_read;
        accept && !hwrite && (haddr[7:0] == macrocell_pkg::terms_addr);
    endsequence

    // cell clock steps: the chosen source seen low, then high
    sequence seq_pin_rise_d;
        (d_pin_w && !ca_sync_r[1]) ##1 (d_pin_w && ca_sync_r[1]);
    endsequence

    sequence seq_term_rise_d;
        (d_term_w && !terms_r[macrocell_pkg::t_ck_bit])
            ##1 (d_term_w && terms_r[macrocell_pkg::t_ck_bit]);
    endsequence

    // ==========================================================
    // bus checks; a write lands one edge after its data phase
    AST_CFG_LANDS: assert property (seq_cfg_write
        |=> ##1 (cfg_r == ($past(hwdata) & macrocell_pkg::cfg_mask)))
        else $error("configuration write lost");

    AST_TERMS_LANDS: assert property (seq_terms_write
        |=> ##1 (terms_r == ($past(hwdata) & macrocell_pkg::terms_mask)))
        else $error("product term write lost");

    // read data stands in the data phase and until the next read
    AST_CFG_READ: assert property (seq_cfg_read
        |=> (hrdata == $past(cfg_r)))
        else $error("configuration read wrong");

    AST_TERMS_READ: assert property (seq_terms_read
        |=> (hrdata == $past(terms_r)))
        else $error("product term read wrong");

    AST_RDATA_HOLD: assert property (!(accept && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved without a read");

    // never a wait state and never an error
    AST_ALWAYS_READY: assert property (hreadyout
        && !hresp)
        else $error("bus not ready or error raised");

    // ==========================================================
    // pin checks; the ports lag the cell by one edge
    AST_PORT_OE_TERM: assert property ((cfg_csel_w && !cfg_bur_w)
        |=> out_pin_oe)
        else $error("enable port off with term clock");

    AST_PORT_OE_PIN: assert property ((!cfg_csel_w && !cfg_frc_w)
        && !cfg_bur_w
            |=> (out_pin_oe == $past(terms_r[macrocell_pkg::t_ck_bit])))
        else $error("enable port not from shared term");

    AST_PORT_OE_TIED: assert property ((cfg_csel_w && cfg_frc_w)
        && (!cfg_bur_w || cfg_mode_w == macrocell_pkg::mode_comb)
            |=> out_pin_oe)
        else $error("enable port not tied on");

    AST_PORT_BURIED: assert property (cfg_bur_w
        && (cfg_mode_w != macrocell_pkg::mode_comb) |=> !out_pin_oe)
        else $error("buried register drives the pin");

    // pin level: bypass term or register state, then polarity
    AST_PORT_COMB: assert property ((cfg_mode_w == macrocell_pkg::mode_comb)
            |=> (out_pin_o == ($past(terms_r[macrocell_pkg::t_comb_bit]) ^ $past(cfg_pol_w))))
        else $error("bypass level wrong at pin");

    AST_PORT_REG: assert property (reg_mode_w
        |=> (out_pin_o == ($past(q_w) ^ $past(cfg_pol_w))))
        else $error("register level wrong at pin");

    // feedback port: legal choices pass their value, the rest read zero
    AST_PORT_FB_PIN: assert property ((cfg_fb_w == macrocell_pkg::fb_pin)
        && (cfg_mode_w <= macrocell_pkg::mode_t)
            |=> (array_feedback == $past(pin_w)))
        else $error("pin feedback wrong");

    AST_PORT_FB_PIN_OFF: assert property ((cfg_fb_w == macrocell_pkg::fb_pin)
        && (cfg_mode_w > macrocell_pkg::mode_t)
            |=> !array_feedback)
        else $error("pin feedback given for jk or sr");

    AST_PORT_FB_NQ: assert property ((cfg_fb_w == macrocell_pkg::fb_nq)
        && reg_mode_w
            |=> (array_feedback == !$past(q_w)))
        else $error("inverted feedback wrong");

    AST_PORT_FB_NQ_OFF: assert property ((cfg_fb_w == macrocell_pkg::fb_nq)
        && !reg_mode_w |=> !array_feedback)
        else $error("inverted feedback given without register");

    // ==========================================================
    // cell clocking seen from the bus side
    AST_PIN_RISE_D: assert property (seq_pin_rise_d
        |=> (q_w == $past(terms_r[macrocell_pkg::t_a_bit])))
        else $error("pin clock rise not captured");

    AST_TERM_RISE_D: assert property (seq_term_rise_d
        |=> (q_w == $past(terms_r[macrocell_pkg::t_a_bit])))
        else $error("term clock rise not captured");

    // pin edges must not reach a register clocked by the term
    AST_TERM_LOW_HOLD: assert property (cfg_csel_w
        && !terms_r[macrocell_pkg::t_ck_bit] |=> $stable(q_w))
        else $error("register moved with term clock low");

endmodule // macrocell_top

/* pld_output_macrocell_tb_top.sv */
// self-checking bench for the output macrocell with its bus wrapper
`timescale 1ns/100ps

module pld_output_macrocell_tb_top;
    // ==========================================================
    // signals and model state
    logic        hclk        = 1'h0;
    logic        hresetn     = 1'h0;
    logic        hsel        = 1'h0;
    logic [31:0] haddr       = 32'h0;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'h0;
    logic [2:0]  hsize       = 3'h0;
    logic [31:0] hwdata      = 32'h0;
    logic        clock_pin_a = 1'h0;
    logic        clock_pin_b = 1'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        out_pin_o;
    logic        out_pin_oe;
    logic        array_feedback;
    logic [31:0] rd;
    int          fails       = 0;
    int          checks_done = 0;
    int          seed        = 39;
    int          q_m         = 0;
    int m_mode = 0, m_pol = 0, m_csel = 0, m_frc = 0, m_fb = 0, m_bur = 0;
    int m_a = 0, m_b = 0, m_cmb = 0, m_ck = 0;

    // free-running bus clock, 8 ns period
    always #4 hclk = ~hclk;
    assign hready = hreadyout;

    macrocell_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .clock_pin_a(clock_pin_a), .clock_pin_b(clock_pin_b), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .out_pin_o(out_pin_o),
        .out_pin_oe(out_pin_oe), .array_feedback(array_feedback));

    // ==========================================================
    // bus, compare and closing tasks
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= macrocell_pkg::htrans_nonseq;
        hwrite <= wr;
        hsize  <= macrocell_pkg::hsize_word;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string s);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %b want %b", $time, s, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic int rnd(input int n);
        return ($random(seed) & 32'h7fff_ffff) % n;
    endfunction

    // model of one active clock edge; q kept raw, polarity only at the pin
    function automatic void clk_model();
        case (m_mode)
            1: q_m = m_a;
            2: q_m = q_m ^ m_a;
            3: q_m = (m_a & m_b) ? 1 - q_m : m_a ? 1 : m_b ? 0 : q_m;
            4: q_m = m_a ? 1 : m_b ? 0 : q_m;
            default: ;
        endcase
    endfunction

    task automatic put_cfg();
        ahb(1'h1, macrocell_pkg::cfg_addr, {23'h0, m_bur[0], m_fb[1:0], m_frc[0],
            m_csel[0], m_pol[0], m_mode[2:0]});
    endtask

    task automatic put_terms();
        ahb(1'h1, macrocell_pkg::terms_addr, {28'h0, m_ck[0], m_cmb[0], m_b[0], m_a[0]});
    endtask

    // pin pulse; long enough for the two-stage synchroniser to see it
    task automatic pulse_pin();
        clock_pin_a <= 1'h1;
        repeat (8) @(posedge hclk);
        clock_pin_a <= 1'h0;
        repeat (8) @(posedge hclk);
    endtask

    // settle, then compare status and pins with the model
    task automatic chk_cell();
        int pin_e, oe_e, ok_e, fb_e;
        repeat (8) @(posedge hclk);
        ahb(1'h0, macrocell_pkg::status_addr, 32'h0);
        pin_e = ((m_mode == 0) ? m_cmb : q_m) ^ m_pol;
        oe_e  = (m_bur != 0 && m_mode != 0) ? 0 : (m_csel | m_frc | m_ck);
        ok_e  = (m_fb == 1) ? (m_mode <= 2) : (m_fb == 2) ? (m_mode != 0) : 0;
        fb_e  = (ok_e == 0) ? 0 : (m_fb == 1) ? pin_e : 1 - q_m;
        chk_bit(rd[macrocell_pkg::st_q_bit], q_m[0], "q");
        chk_bit(rd[macrocell_pkg::st_pin_bit], pin_e[0], "pin");
        chk_bit(out_pin_o, pin_e[0], "pin port");
        chk_bit(rd[macrocell_pkg::st_oe_bit], oe_e[0], "oe");
        chk_bit(out_pin_oe, oe_e[0], "oe port");
        chk_bit(rd[macrocell_pkg::st_fbok_bit], ok_e[0], "fb ok");
        chk_bit(rd[macrocell_pkg::st_fb_bit], fb_e[0], "fb");
        chk_bit(array_feedback, fb_e[0], "fb port");
    endtask

    // ==========================================================
    // watchdog: the whole run needs well under this span
    initial begin
        repeat (30000) @(posedge hclk);
        fails++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        chk_cell();
        ahb(1'h0, macrocell_pkg::cfg_addr, 32'h0);
        chk_word(rd, macrocell_pkg::cfg_reset, "cfg reset");
        ahb(1'h1, 8'h0c, 32'hffff_ffff);
        ahb(1'h0, 8'h0c, 32'h0);
        chk_word(rd, 32'h0, "unmapped");
        $display("test reset and map done");
        // shared term as clock; the pin must not clock the register here
        for (int i = 0; i < 24; i++) begin
            m_mode = 1 + i % 4;
            m_pol = rnd(2); m_csel = 1; m_frc = rnd(2); m_fb = 1 + rnd(2);
            m_bur = (m_fb == 2) ? rnd(2) : 0;
            m_a = rnd(2); m_b = rnd(2); m_cmb = rnd(2); m_ck = 0;
            put_cfg();
            ahb(1'h0, macrocell_pkg::cfg_addr, 32'h0);
            chk_word(rd, {23'h0, m_bur[0], m_fb[1:0], m_frc[0], 1'h1, m_pol[0],
                m_mode[2:0]}, "cfg");
            put_terms();
            pulse_pin();
            chk_cell();
            m_ck = 1;
            put_terms();
            clk_model();
            chk_cell();
        end
        $display("test term clock done");
        // pin clock; the shared term now steers the enable only
        for (int i = 0; i < 16; i++) begin
            m_mode = 1 + i % 4;
            m_pol = rnd(2); m_csel = 0; m_frc = rnd(2); m_fb = 2; m_bur = 0;
            m_a = rnd(2); m_b = rnd(2); m_ck = 0;
            put_cfg();
            put_terms();
            m_ck = 1;
            put_terms();
            chk_cell();
            pulse_pin();
            clk_model();
            m_ck = 0;
            put_terms();
            chk_cell();
        end
        $display("test pin clock done");
        // register bypassed
        for (int i = 0; i < 8; i++) begin
            m_mode = 0; m_pol = rnd(2); m_csel = 0; m_frc = rnd(2); m_fb = 1 + rnd(2);
            m_cmb = rnd(2); m_ck = 1;
            put_cfg();
            put_terms();
            chk_cell();
        end
        $display("test combinatorial done");
        finish_test();
    end
endmodule // pld_output_macrocell_tb_top
